//--- sai_pkg.sv
package sai_pkg;

    // Register map
    localparam logic [15:0] SAI_CTRL_ADDR   = 16'h081f;
    localparam logic [7:0]  SAI_CTRL_RESET  = 8'h00;
    localparam int          SAI_WCP_BIT     = 4;
    localparam int          SAI_BCP_BIT     = 3;
    localparam int          SAI_FMT_LSB     = 0;
    localparam int          SAI_CFG_BITS    = 5;

    // Format field codes
    localparam logic [2:0]  SAI_FMT_I2S     = 3'h0;
    localparam logic [2:0]  SAI_FMT_LEFT    = 3'h1;
    localparam logic [2:0]  SAI_FMT_TDM     = 3'h2;
    localparam logic [2:0]  SAI_FMT_RIGHT   = 3'h3;

    // Framing figures
    localparam int          SAI_PIN_COUNT   = 4;
    localparam int          SAI_WORD_BITS   = 24;
    localparam logic [4:0]  SAI_WORD_CNT    = 5'h18;
    localparam logic [4:0]  SAI_TDM_LSB_POS = 5'h18;   // One delay bit plus 24 data bits
    localparam logic [7:0]  SAI_TDM_POS_END = 8'hff;   // 8 slots of 32 bit clocks

    // Captured words leaving the port
    typedef struct packed {
        logic                                    valid;
        logic [2:0]                              channel;
        logic [SAI_PIN_COUNT-1:0][SAI_WORD_BITS-1:0] word;
    } sai_sample_t;

    function automatic logic sai_is_tdm(input logic [2:0] fmt);
        return fmt == SAI_FMT_TDM;
    endfunction : sai_is_tdm

    function automatic logic sai_is_stereo(input logic [2:0] fmt);
        return (fmt == SAI_FMT_I2S) || (fmt == SAI_FMT_LEFT) || (fmt == SAI_FMT_RIGHT);
    endfunction : sai_is_stereo

endpackage : sai_pkg

//--- sai_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sai_sync
    import sai_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,   // Core clock
    input  wire logic             resetn,  // Async reset, active low
    input  wire logic [WIDTH-1:0] din,     // Raw pin levels
    output var  logic [WIDTH-1:0] dout     // Filtered levels
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } sai_sync_state_t;

    sai_sync_state_t st;
    sai_sync_state_t next_st;

    // Three stages; a level is taken only once stages two and three agree
    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1; // Only stage two looks at stage one
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.level[i] = st.s3[i];
            end
        end
    end

    // Levels start low, so a pin idling high shows one rising step after reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.level;

endmodule : sai_sync

`default_nettype wire

//--- sai_input_port.sv
// How it works
// - One 8-bit control register at 0x081f resets to zero, top three bits read zero.
// - In stereo formats left data comes with word clock low, right with high; polarity 1 swaps.
// - In multiplexed mode a frame starts after the falling word-clock edge, or rising with polarity 1.
// - A pulse word clock works too: its first edge starts the frame, low pulse or high pulse by polarity.
// - The 3-bit format field selects the serial format the port expects.
// - Codes are 000 I2S, 001 left-justified, 010 eight-channel multiplexed, 011 right-justified 24-bit.
// - Left- and right-justified framing puts the first channel on word clock high, so polarity is set.
// - The multiplexed stream arrives only on the first serial input pin.
// - In a multiplexed frame channels 0 to 3 fill the first half and 4 to 7 the second.
// - In multiplexed mode each slot's MSB comes one bit clock after the slot starts.
`timescale 1ns/1ps
`default_nettype none

module sai_input_port
    import sai_pkg::*;
(
    input  wire logic                     clock,             // Core clock, 25 MHz
    input  wire logic                     resetn,            // Async reset, active low
    input  wire logic [15:0]              reg_addr,          // Register address
    input  wire logic [7:0]               reg_wdata,         // Write data
    input  wire logic                     reg_write,         // Write strobe
    input  wire logic                     reg_read,          // Read strobe
    output var  logic [7:0]               reg_rdata,         // Read data, one cycle after strobe
    input  wire logic                     word_clock_pin,    // Input word clock
    input  wire logic                     bit_clock_pin,     // Input bit clock
    input  wire logic [SAI_PIN_COUNT-1:0] serial_input_pins, // Serial data, pin 0 first
    output var  sai_sample_t              sample_out         // Captured words
);

    typedef struct packed {
        logic [SAI_CFG_BITS-1:0]                     cfg;
        logic [7:0]                                  rdata;
        logic                                        bclk_prev;
        logic [1:0]                                  lvl_hist;
        logic [SAI_PIN_COUNT-1:0][SAI_WORD_BITS-1:0] shreg;
        logic [4:0]                                  cnt;
        logic [7:0]                                  pos;
        logic                                        armed;
        sai_sample_t                                 out;
    } sai_state_t;

    sai_state_t st;
    sai_state_t next_st;

    logic [SAI_PIN_COUNT+1:0] pins_s;
    logic                     wclk_s;
    logic                     bclk_s;
    logic [SAI_PIN_COUNT-1:0] din_s;
    logic                     wcp;
    logic                     bcp;
    logic [2:0]               fmt;
    logic                     sample_edge;
    logic                     tdm_start;

    // Pins come from the link's domain; the bit clock is only sampled, never used as a clock
    sai_sync #(
        .WIDTH(SAI_PIN_COUNT + 2)
    ) u_sync (
        .clock  (clock),
        .resetn (resetn),
        .din    ({word_clock_pin, bit_clock_pin, serial_input_pins}),
        .dout   (pins_s)
    );

    assign wclk_s = pins_s[SAI_PIN_COUNT+1];
    assign bclk_s = pins_s[SAI_PIN_COUNT];
    assign din_s  = pins_s[SAI_PIN_COUNT-1:0];
    assign wcp    = st.cfg[SAI_WCP_BIT];
    assign bcp    = st.cfg[SAI_BCP_BIT];
    assign fmt    = st.cfg[SAI_FMT_LSB +: 3];

    // Sample on the edge opposite the sender's change edge: rising for 0, falling for 1
    assign sample_edge = (bclk_s != st.bclk_prev) && (bclk_s == ~bcp);
    // Frame begins at the first edge into the active level, square or pulse clock alike
    assign tdm_start = sample_edge && (wclk_s == wcp) && (st.lvl_hist[0] != wcp);

    // Next-state logic for the whole port
    always_comb begin
        logic                     i2s;
        logic                     ref_now;
        logic                     ref_old;
        logic [SAI_WORD_BITS-1:0] w;
        i2s     = (fmt == SAI_FMT_I2S);
        ref_now = 1'b0;
        ref_old = 1'b0;
        w       = '0;
        next_st = st;
        next_st.out.valid = 1'b0;
        next_st.bclk_prev = bclk_s;

        // Register port; only the five live bits are stored
        if (reg_write && reg_addr == SAI_CTRL_ADDR) begin
            next_st.cfg = reg_wdata[SAI_CFG_BITS-1:0];
        end
        if (reg_read) begin
            next_st.rdata = (reg_addr == SAI_CTRL_ADDR) ? {3'h0, st.cfg} : 8'h00;
        end

        if (sample_edge) begin
            next_st.lvl_hist = {st.lvl_hist[0], wclk_s};
            if (sai_is_tdm(fmt)) begin
                // Only pin zero carries the multiplexed stream
                next_st.shreg[0] = {st.shreg[0][SAI_WORD_BITS-2:0], din_s[0]};
                if (tdm_start) begin
                    next_st.pos   = 8'h00;
                    next_st.armed = 1'b1;
                end else if (st.armed && st.pos != SAI_TDM_POS_END) begin
                    next_st.pos = st.pos + 8'h01;
                end else begin
                    next_st.armed = 1'b0;
                end
                // Bit 0 of a slot is the delay bit, so the LSB lands at position 24
                if (next_st.armed && next_st.pos[4:0] == SAI_TDM_LSB_POS) begin
                    next_st.out.valid   = 1'b1;
                    next_st.out.channel = next_st.pos[7:5];
                    next_st.out.word    = '0;
                    next_st.out.word[0] = next_st.shreg[0];
                end
            end else if (sai_is_stereo(fmt)) begin
                // I2S boundary trails the word clock by one bit; justified formats do not
                ref_now = i2s ? st.lvl_hist[0] : wclk_s;
                ref_old = i2s ? st.lvl_hist[1] : st.lvl_hist[0];
                if (ref_now != ref_old) begin
                    next_st.out.valid   = 1'b1;
                    // Low level is left unless polarity swaps it
                    next_st.out.channel = {2'h0, ref_old ^ wcp};
                    for (int i = 0; i < SAI_PIN_COUNT; i++) begin
                        w = st.shreg[i];
                        if (fmt != SAI_FMT_RIGHT) begin
                            w = w << (SAI_WORD_CNT - st.cnt);
                        end
                        next_st.out.word[i] = w;
                        next_st.shreg[i]    = {{(SAI_WORD_BITS-1){1'b0}}, din_s[i]};
                    end
                    next_st.cnt = 5'h01;
                end else if (fmt == SAI_FMT_RIGHT || st.cnt < SAI_WORD_CNT) begin
                    // Right-justified keeps the last 24 bits; others keep the first 24
                    for (int i = 0; i < SAI_PIN_COUNT; i++) begin
                        next_st.shreg[i] = {st.shreg[i][SAI_WORD_BITS-2:0], din_s[i]};
                    end
                    if (st.cnt < SAI_WORD_CNT) begin
                        next_st.cnt = st.cnt + 5'h01;
                    end
                end
            end
        end
    end

    // State register; reserved format codes leave capture idle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st       <= '0;
            st.cfg   <= SAI_CTRL_RESET[SAI_CFG_BITS-1:0];
            st.rdata <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata  = st.rdata;
    assign sample_out = st.out;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_ctrl_write;
        reg_write && reg_addr == SAI_CTRL_ADDR;
    endsequence

    sequence s_ctrl_read;
        reg_read && reg_addr == SAI_CTRL_ADDR && !reg_write;
    endsequence

    chk_reg_write: assert property (
        s_ctrl_write |=> st.cfg == $past(reg_wdata[SAI_CFG_BITS-1:0]))
        else $error("control write not stored");

    chk_reg_readback: assert property (
        s_ctrl_read |=> reg_rdata == {3'h0, $past(st.cfg)})
        else $error("control read wrong");

    chk_upper_zero: assert property (
        reg_rdata[7:5] == 3'h0)
        else $error("upper control bits not zero");

    chk_unmapped_read: assert property (
        reg_read && reg_addr != SAI_CTRL_ADDR |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    chk_sample_edge: assert property (
        sample_edge |-> bclk_s != bcp && $past(bclk_s) == bcp)
        else $error("sampled on sender edge");

    chk_tdm_start: assert property (
        sai_is_tdm(fmt) && tdm_start && !reg_write |=> st.pos == 8'h00 && st.armed)
        else $error("frame start not taken");

    chk_tdm_pin: assert property (
        sample_out.valid && sai_is_tdm(fmt) |-> sample_out.word[3:1] == '0)
        else $error("multiplexed data off pin zero");

    chk_tdm_slot: assert property (
        sample_out.valid && sai_is_tdm(fmt) && !$past(reg_write)
            |-> sample_out.channel == st.pos[7:5] && st.pos[4:0] == SAI_TDM_LSB_POS)
        else $error("slot channel mismatch");

    chk_stereo_side: assert property (
        sample_out.valid && fmt == SAI_FMT_LEFT && !$past(reg_write)
            |-> sample_out.channel[0] == ($past(st.lvl_hist[0]) ^ wcp))
        else $error("stereo side wrong");

    chk_fmt_idle: assert property (
        !sai_is_tdm(fmt) && !sai_is_stereo(fmt) && !$past(reg_write) |-> !sample_out.valid)
        else $error("capture in reserved format");

endmodule : sai_input_port

`default_nettype wire

//--- sai_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module sai_src_model
    import sai_pkg::*;
(
    output var logic                     word_clock, // Frame clock towards the port
    output var logic                     bit_clock,  // Bit clock, runs through all frames of a send, still between sends
    output var logic [SAI_PIN_COUNT-1:0] sdata       // Serial data lines
);
    // Idle levels before the first frame
    initial begin
        word_clock = 1'b1;
        bit_clock  = 1'b1;
        sdata      = '0;
    end

    // Sends frames of 32-bit slots: two slots on every pin, or eight slots on pin zero only
    task automatic send(input bit tdm, input int plen, input int off, input logic wcp,
                        input logic bcp, input int nfr, input logic [23:0] w [8][4]);
        int nb;
        int s;
        int p;
        nb = tdm ? 256 : 64;
        bit_clock = ~bcp;
        #333;
        for (int f = 0; f < nfr; f++) begin
            for (int b = 0; b < nb; b++) begin
                s = b / 32;
                p = b % 32 - off;
                bit_clock = bcp;
                if (tdm)
                    word_clock = (b < plen) ? wcp : ~wcp;
                else
                    word_clock = s[0] ? ~wcp : wcp;
                // Spare pins toggle in multiplexed mode so a leak into the words shows
                for (int i = 0; i < SAI_PIN_COUNT; i++)
                    sdata[i] = (tdm && i > 0) ? b[i] :
                               (p >= 0 && p < 24) ? w[s][tdm ? 0 : i][23 - p] : 1'b0;
                #160;
                bit_clock = ~bcp;
                #160;
            end
        end
        // Released lines must not keep showing the last bit
        sdata = ~sdata;
    endtask : send
endmodule : sai_src_model

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHECK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module tb_top
    import sai_pkg::*;
;

    logic                     clock;
    logic                     resetn;
    logic                     reg_write;
    logic                     reg_read;
    logic [15:0]              reg_addr;
    logic [7:0]               reg_wdata;
    logic [7:0]               reg_rdata;
    logic                     wclk;
    logic                     bclk;
    logic [SAI_PIN_COUNT-1:0] sdata;
    sai_sample_t              sample_out;
    sai_sample_t              seen [$];
    logic [23:0]              wm [8][4];
    int                       mismatches = 0;
    int                       cmp_count = 0;
    int                       cycles = 0;

    sai_input_port u_dut (
        .clock             (clock),
        .resetn            (resetn),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_write         (reg_write),
        .reg_read          (reg_read),
        .reg_rdata         (reg_rdata),
        .word_clock_pin    (wclk),
        .bit_clock_pin     (bclk),
        .serial_input_pins (sdata),
        .sample_out        (sample_out)
    );

    sai_src_model u_src (
        .word_clock (wclk),
        .bit_clock  (bclk),
        .sdata      (sdata)
    );

    // Core clock, 40 ns
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Hang guard, well above the roughly 20200 cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            end_of_test();
        end
    end

    // Every captured word is logged; valid lasts one cycle so each edge is looked at
    always @(posedge clock)
        if (sample_out.valid === 1'b1)
            seen.push_back(sample_out);

    task automatic end_of_test;
        $display("Counts: %0d mismatches, %0d comparisons", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_chk(input logic [15:0] a, input logic [7:0] ex);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        `CHECK("reg_rdata", ex, reg_rdata)
    endtask : reg_chk

    task automatic test_regs;
        reg_chk(SAI_CTRL_ADDR, 8'h00);
        reg_wr(SAI_CTRL_ADDR, 8'hff);
        reg_chk(SAI_CTRL_ADDR, 8'h1f);
        reg_wr(16'h0820, 8'h00);
        reg_chk(16'h0820, 8'h00);
        reg_chk(SAI_CTRL_ADDR, 8'h1f);
        $display("registers done");
    endtask : test_regs

    // Configures, sends three frames, then looks for one whole frame among the captures
    task automatic run(input string nm, input logic [7:0] cfg, input bit tdm, input int plen,
                       input int off, input int k);
        sai_sample_t ex [$];
        sai_sample_t e;
        int          at;
        for (int c = 0; c < 8; c++)
            for (int i = 0; i < 4; i++)
                wm[c][i] = 24'(32'h810001 | (k << 12) | (c << 8) | (i << 4));
        reg_wr(SAI_CTRL_ADDR, cfg);
        seen.delete();
        u_src.send(tdm, plen, off, cfg[SAI_WCP_BIT], cfg[SAI_BCP_BIT], 3, wm);
        repeat (20) @(posedge clock);
        for (int c = 0; c < (tdm ? 8 : 2); c++) begin
            e = '0;
            e.valid = 1'b1;
            e.channel = 3'(c);
            for (int i = 0; i < 4; i++)
                if (!tdm || i == 0)
                    e.word[i] = wm[c][i];
            ex.push_back(e);
        end
        // The first stereo word after a change may be partial, so the match may start later
        at = seen.size();
        for (int j = seen.size() - 1; j >= 0; j--)
            if (seen[j] === ex[0])
                at = j;
        if (cfg[2:0] > 3'h3)
            `CHECK(nm, 0, seen.size())
        else
            for (int j = 0; j < ex.size(); j++)
                `CHECK(nm, ex[j], (at + j < seen.size()) ? seen[at + j] : '0)
        $display("%s done", nm);
    endtask : run

    task automatic test_i2s;
        run("i2s", 8'h00, 0, 0, 1, 1);
    endtask : test_i2s

    task automatic test_i2s_swap;
        run("i2s_swap", 8'h18, 0, 0, 1, 2);
    endtask : test_i2s_swap

    task automatic test_left;
        run("left", 8'h11, 0, 0, 0, 3);
    endtask : test_left

    task automatic test_right;
        run("right", 8'h1b, 0, 0, 8, 4);
    endtask : test_right

    task automatic test_tdm;
        run("tdm", 8'h02, 1, 128, 1, 5);
    endtask : test_tdm

    task automatic test_pulse;
        run("tdm_pulse", 8'h12, 1, 1, 1, 6);
    endtask : test_pulse

    task automatic test_reserved;
        run("reserved", 8'h05, 0, 0, 1, 7);
    endtask : test_reserved

    // Main sequence
    initial begin
        resetn    = 1'b0;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = 16'h0000;
        reg_wdata = 8'h00;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        repeat (5) @(posedge clock);
        test_regs();
        test_i2s();
        test_i2s_swap();
        test_left();
        test_right();
        test_tdm();
        test_pulse();
        test_reserved();
        end_of_test();
    end
endmodule : tb_top

`default_nettype wire
